// ### hw/ersp_pkg.sv
// Constants shared by the two-wire slave port of the event recorder
package ersp_pkg;

   // Slave address and direction bit
   localparam logic [6:0] SLAVE_ADDR = 7'h4a;
   localparam logic DIR_WRITE = 1'b0;
   localparam logic DIR_READ = 1'b1;

   // Byte framing: eight data bits, then the acknowledge slot
   localparam int BYTE_BITS = 8;
   localparam logic [3:0] LAST_DATA_BIT = 4'h7;
   localparam logic [3:0] ACK_SLOT = 4'h8;
   localparam logic ACK_LEVEL = 1'b0;

   // Register pointer and data widths
   localparam int PTR_W = 8;
   localparam int DATA_W = 8;
   localparam logic [PTR_W-1:0] PTR_RESET = 8'h00;
   localparam logic [PTR_W-1:0] PTR_STEP = 8'h01;

   // Crossing into the system clock: lines scl, sda and the bit toggle
   localparam int SYNC_W = 3;
   localparam int SYNC_SCL = 2;
   localparam int SYNC_SDA = 1;
   localparam int SYNC_TGL = 0;
   localparam logic [SYNC_W-1:0] SYNC_RESET = 3'h6;

   // Serial clock rates served and the system clock rate, in kHz
   localparam int STD_SCL_KHZ = 100;
   localparam int FAST_SCL_KHZ = 400;
   localparam int SYS_CLK_KHZ = 20000;
   localparam int FAST_HALF_CYCLES = SYS_CLK_KHZ / (2 * FAST_SCL_KHZ);

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_PTR,
      ST_WR,
      ST_RD,
      ST_IGN
   } ersp_state_e;

endpackage

// ### hw/ersp_sync.sv
// Two-flop synchroniser for the link lines and the bit toggle
`timescale 1ns/100ps
module ersp_sync
   import ersp_pkg::*;
(
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic [SYNC_W-1:0] d_i,
   output logic [SYNC_W-1:0] q_o
);

   logic [SYNC_W-1:0] meta_q;

   // First stage feeds only the second stage
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         meta_q <= SYNC_RESET;
         q_o <= SYNC_RESET;
      end else begin
         meta_q <= d_i;
         q_o <= meta_q;
      end
   end

endmodule

// ### hw/ersp_link_sampler.sv
// Serial clock domain: samples the data line on each clock rise
`timescale 1ns/100ps
module ersp_link_sampler (
   input wire logic scl_i,
   input wire logic rstn_i,
   input wire logic sda_i,
   output logic bit_o,
   output logic tgl_o
);

   // Bit is held stable until the next rise; the toggle marks it new
   always_ff @(posedge scl_i or negedge rstn_i) begin
      if (!rstn_i) begin
         bit_o <= 1'b1;
         tgl_o <= 1'b0;
      end else begin
         bit_o <= sda_i;
         tgl_o <= ~tgl_o;
      end
   end

endmodule

// ### hw/ersp_slave.sv
// Two-wire slave port of the event recorder: protocol engine and pointer
`timescale 1ns/100ps
module ersp_slave
   import ersp_pkg::*;
(
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   output logic [PTR_W-1:0] rd_addr_o,
   input wire logic [DATA_W-1:0] rd_data_i,
   output logic rd_stb_o,
   output logic [PTR_W-1:0] wr_addr_o,
   output logic [DATA_W-1:0] wr_data_o,
   output logic wr_stb_o,
   output logic addressed_o,
   output logic bus_idle_o,
   output logic frame_start_o,
   output logic frame_stop_o
);

   // Bit counter decodes used in several places
   function automatic logic is_ack_slot(input logic [3:0] cnt);
      is_ack_slot = (cnt == ACK_SLOT);
   endfunction

   function automatic logic is_last_bit(input logic [3:0] cnt);
      is_last_bit = (cnt == LAST_DATA_BIT);
   endfunction

   logic link_bit;
   logic link_tgl;
   logic [SYNC_W-1:0] sync_w;
   logic scl_s;
   logic sda_s;
   logic tgl_s;
   logic scl_q;
   logic sda_q;
   logic tgl_q;
   logic start_ev;
   logic stop_ev;
   logic rise_ev;
   logic fall_ev;
   logic active;
   logic bit_ev;
   logic byte_ev;
   logic ack_ev;
   logic load_ev;
   logic addr_hit;
   logic [DATA_W-1:0] rx_byte;
   ersp_state_e state_q;
   logic [3:0] bit_cnt_q;
   logic ack_q;
   logic [DATA_W-1:0] rx_q;
   logic [DATA_W-1:0] tx_q;
   logic [PTR_W-1:0] ptr_q;
   logic sda_oe_q;
   logic wr_stb_q;
   logic [PTR_W-1:0] wr_addr_q;
   logic [DATA_W-1:0] wr_data_q;
   logic rd_stb_q;
   logic addressed_q;
   logic bus_idle_q;
   logic frame_start_q;
   logic frame_stop_q;

   // Serial clock domain captures each bit on the master's clock
   ersp_link_sampler u_link (
      .scl_i(scl_i),
      .rstn_i(rstn_i),
      .sda_i(sda_i),
      .bit_o(link_bit),
      .tgl_o(link_tgl)
   );

   // Lines and bit toggle cross into the system clock
   ersp_sync u_sync (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .d_i({scl_i, sda_i, link_tgl}),
      .q_o(sync_w)
   );

   assign scl_s = sync_w[SYNC_SCL];
   assign sda_s = sync_w[SYNC_SDA];
   assign tgl_s = sync_w[SYNC_TGL];

   // Previous samples for edge detection
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         tgl_q <= 1'b0;
      end else begin
         scl_q <= scl_s;
         sda_q <= sda_s;
         tgl_q <= tgl_s;
      end
   end

   // Data edges while clock high are control, not data
   assign start_ev = scl_s & scl_q & sda_q & ~sda_s;
   assign stop_ev = scl_s & scl_q & ~sda_q & sda_s;

   // Bit events follow the master's clock; a fast half period spans many system cycles
   assign rise_ev = tgl_s ^ tgl_q;
   assign fall_ev = scl_q & ~scl_s;

   assign active = (state_q != ST_IDLE) && (state_q != ST_IGN);
   assign bit_ev = rise_ev && active && !is_ack_slot(bit_cnt_q);
   assign byte_ev = rise_ev && active && is_last_bit(bit_cnt_q);
   assign ack_ev = rise_ev && active && is_ack_slot(bit_cnt_q);
   assign rx_byte = {rx_q[DATA_W-2:0], link_bit};
   assign addr_hit = (rx_byte[DATA_W-1:1] == SLAVE_ADDR);

   // Load a byte after our address acknowledge or a master acknowledge
   assign load_ev = ack_ev && (state_q == ST_RD) && (ack_q || (link_bit == ACK_LEVEL));

   // Protocol state
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_q <= ST_IDLE;
      end else if (stop_ev) begin
         state_q <= ST_IDLE;
      end else if (start_ev) begin
         state_q <= ST_ADDR;
      end else if (byte_ev) begin
         case (state_q)
            ST_ADDR: begin
               if (addr_hit && rx_byte[0] == DIR_READ) begin
                  state_q <= ST_RD;
               end else if (addr_hit && rx_byte[0] == DIR_WRITE) begin
                  state_q <= ST_PTR;
               end else begin
                  state_q <= ST_IGN;
               end
            end
            ST_PTR: begin
               state_q <= ST_WR;
            end
            default: begin
               state_q <= state_q;
            end
         endcase
      end else if (ack_ev && state_q == ST_RD && !ack_q && link_bit != ACK_LEVEL) begin
         state_q <= ST_IGN;
      end
   end

   // Bit position within the byte and its acknowledge slot
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         bit_cnt_q <= 4'h0;
      end else if (stop_ev || start_ev) begin
         bit_cnt_q <= 4'h0;
      end else if (bit_ev) begin
         bit_cnt_q <= bit_cnt_q + 4'h1;
      end else if (ack_ev) begin
         bit_cnt_q <= 4'h0;
      end
   end

   // Acknowledge owed by the port in the coming slot
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ack_q <= 1'b0;
      end else if (stop_ev || start_ev || ack_ev) begin
         ack_q <= 1'b0;
      end else if (byte_ev) begin
         case (state_q)
            ST_ADDR: begin
               ack_q <= addr_hit;
            end
            ST_PTR: begin
               ack_q <= 1'b1;
            end
            ST_WR: begin
               ack_q <= 1'b1;
            end
            default: begin
               ack_q <= 1'b0;
            end
         endcase
      end
   end

   // Receive shift register, most significant bit first
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rx_q <= 8'h00;
      end else if (start_ev) begin
         rx_q <= 8'h00;
      end else if (bit_ev) begin
         rx_q <= rx_byte;
      end
   end

   // Transmit shift register, loaded from the pointed register
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tx_q <= 8'hff;
      end else if (load_ev) begin
         tx_q <= rd_data_i;
      end else if (fall_ev && state_q == ST_RD && !is_ack_slot(bit_cnt_q)) begin
         tx_q <= {tx_q[DATA_W-2:0], 1'b1};
      end
   end

   // Register pointer
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ptr_q <= PTR_RESET;
      end else if (byte_ev && state_q == ST_PTR) begin
         ptr_q <= rx_byte;
      end else if (byte_ev && state_q == ST_WR) begin
         ptr_q <= ptr_q + PTR_STEP;
      end else if (load_ev) begin
         ptr_q <= ptr_q + PTR_STEP;
      end
   end

   // Data line drive, changed after the clock has fallen, or released on start or stop
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sda_oe_q <= 1'b0;
      end else if (start_ev || stop_ev) begin
         sda_oe_q <= 1'b0;
      end else if (fall_ev) begin
         if (is_ack_slot(bit_cnt_q)) begin
            sda_oe_q <= ack_q;
         end else if (state_q == ST_RD) begin
            sda_oe_q <= ~tx_q[DATA_W-1];
         end else begin
            sda_oe_q <= 1'b0;
         end
      end
   end

   // Register write strobe, one cycle per written byte
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wr_stb_q <= 1'b0;
      end else begin
         wr_stb_q <= byte_ev && (state_q == ST_WR);
      end
   end

   // Written address and data, held until the next write
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wr_addr_q <= PTR_RESET;
         wr_data_q <= 8'h00;
      end else if (byte_ev && state_q == ST_WR) begin
         wr_addr_q <= ptr_q;
         wr_data_q <= rx_byte;
      end
   end

   // Read strobe marks each byte taken for transmission
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rd_stb_q <= 1'b0;
      end else begin
         rd_stb_q <= load_ev;
      end
   end

   // Session status and frame markers
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         addressed_q <= 1'b0;
         frame_start_q <= 1'b0;
         frame_stop_q <= 1'b0;
      end else begin
         addressed_q <= (state_q == ST_PTR) || (state_q == ST_WR) || (state_q == ST_RD);
         frame_start_q <= start_ev;
         frame_stop_q <= stop_ev;
      end
   end

   // Bus busy from start until stop
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         bus_idle_q <= 1'b1;
      end else if (start_ev) begin
         bus_idle_q <= 1'b0;
      end else if (stop_ev) begin
         bus_idle_q <= 1'b1;
      end
   end

   // Open-drain output: only ever pulls low
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sda_o <= 1'b0;
      end else begin
         sda_o <= 1'b0;
      end
   end

   assign sda_oe_o = sda_oe_q;
   assign rd_addr_o = ptr_q;
   assign rd_stb_o = rd_stb_q;
   assign wr_addr_o = wr_addr_q;
   assign wr_data_o = wr_data_q;
   assign wr_stb_o = wr_stb_q;
   assign addressed_o = addressed_q;
   assign bus_idle_o = bus_idle_q;
   assign frame_start_o = frame_start_q;
   assign frame_stop_o = frame_stop_q;

endmodule

// ### sim/ersp_slave_asserts.sv
// Concurrent checks on the two-wire slave port
`timescale 1ns/100ps
module ersp_slave_asserts
   import ersp_pkg::*;
(
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic [PTR_W-1:0] rd_addr_o,
   input wire logic [DATA_W-1:0] rd_data_i,
   input wire logic rd_stb_o,
   input wire logic [PTR_W-1:0] wr_addr_o,
   input wire logic [DATA_W-1:0] wr_data_o,
   input wire logic wr_stb_o,
   input wire logic addressed_o,
   input wire logic bus_idle_o,
   input wire logic frame_start_o,
   input wire logic frame_stop_o
);
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (!rstn_i);
   drive_low_a: assert property (sda_o == 1'b0) else $error("sda_o not low");
   rise_scl_low_a: assert property ($rose(sda_oe_o) |-> !scl_i) else $error("drive with scl high");
   rise_addressed_a: assert property ($rose(sda_oe_o) |-> addressed_o) else $error("drive unaddressed");
   idle_quiet_a: assert property (bus_idle_o |-> !sda_oe_o) else $error("drive when idle");
   start_busy_a: assert property (frame_start_o |-> ##[0:2] !bus_idle_o) else $error("start kept idle");
   stop_idle_a: assert property (frame_stop_o |-> ##[0:2] (bus_idle_o && !sda_oe_o)) else $error("stop");
   stop_unaddr_a: assert property (frame_stop_o |-> ##[1:3] !addressed_o) else $error("stop addressed");
   wr_pulse_a: assert property (wr_stb_o |=> !wr_stb_o) else $error("write strobe long");
   wr_step_a: assert property (wr_stb_o |-> ##[0:1] (rd_addr_o == wr_addr_o + PTR_STEP)) else $error("step");
   rd_pulse_a: assert property (rd_stb_o |-> addressed_o ##1 !rd_stb_o) else $error("read strobe");
endmodule
bind ersp_slave ersp_slave_asserts ersp_slave_asserts_inst (.clk_i(clk_i), .rstn_i(rstn_i), .scl_i(scl_i),
   .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .rd_addr_o(rd_addr_o), .rd_data_i(rd_data_i),
   .rd_stb_o(rd_stb_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o), .wr_stb_o(wr_stb_o),
   .addressed_o(addressed_o), .bus_idle_o(bus_idle_o), .frame_start_o(frame_start_o),
   .frame_stop_o(frame_stop_o));

// ### sim/ersp_master.sv
// Two-wire bus master model on its own time base
`timescale 1ns/100ps
module ersp_master (
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_o
);
   logic tick = 1'b0;
   int h = 16;
   initial #13 forever #40 tick = ~tick;
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic w(input int n);
      repeat (n) @(posedge tick);
   endtask
   task automatic start();
      sda_o = 1'b1;
      w(h / 2);
      scl_o = 1'b1;
      w(h / 2);
      sda_o = 1'b0;
      w(h);
      scl_o = 1'b0;
   endtask
   task automatic stop();
      w(h / 2);
      sda_o = 1'b0;
      w(h / 2);
      scl_o = 1'b1;
      w(h);
      sda_o = 1'b1;
      w(h);
   endtask
   task automatic bit9(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) begin
         w(h / 2);
         sda_o = tx[i];
         w(h / 2);
         scl_o = 1'b1;
         w(h / 2);
         rx[i] = sda_i;
         w(h / 2);
         scl_o = 1'b0;
      end
   endtask
endmodule

// ### sim/ersp_slave_test.sv
// Self-checking bench for the two-wire slave port
`timescale 1ns/100ps
module ersp_slave_test;
   import ersp_pkg::*;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic scl, msda, sda_oe_o, sda_o, rd_stb_o, wr_stb_o, addressed_o, bus_idle_o, fst, fsp;
   logic [7:0] rd_addr_o, wr_addr_o, wr_data_o, p, d0, d1;
   logic [7:0] rd_data_i = 8'h00;
   logic [7:0] mem [256];
   logic [15:0] wq [$];
   logic [8:0] rx;
   logic [15:0] lf = 16'h3364;
   int miscompares = 0;
   int check_count = 0;
   wire sda = msda & (sda_oe_o ? sda_o : 1'b1);
   always #25 clk_i = ~clk_i;
   ersp_master ersp_master_inst (.sda_i(sda), .scl_o(scl), .sda_o(msda));
   ersp_slave ersp_slave_inst (.clk_i(clk_i), .rstn_i(rstn_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe_o(sda_oe_o), .rd_addr_o(rd_addr_o), .rd_data_i(rd_data_i), .rd_stb_o(rd_stb_o),
      .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o), .wr_stb_o(wr_stb_o), .addressed_o(addressed_o),
      .bus_idle_o(bus_idle_o), .frame_start_o(fst), .frame_stop_o(fsp));
   always @(negedge clk_i) rd_data_i <= mem[rd_addr_o];
   always @(posedge clk_i) if (wr_stb_o) wq.push_back({wr_addr_o, wr_data_o});
   function automatic logic [7:0] rnd();
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      return lf[7:0];
   endfunction
   function automatic logic [7:0] abyte(input logic dir);
      return {SLAVE_ADDR, dir};
   endfunction
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wb(input logic [7:0] d, input logic e);
      ersp_master_inst.bit9({d, 1'b1}, rx);
      chk("ack", {7'h00, e}, {7'h00, rx[0]});
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      #3000000;
      miscompares++;
      give_verdict();
   end
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = rnd();
      repeat (12) @(negedge clk_i);
      rstn_i = 1'b1;
      repeat (4) @(negedge clk_i);
      chk("idle", 8'h01, {7'h00, bus_idle_o});
      for (int s = 0; s < 2; s++) begin
         ersp_master_inst.h = s ? 63 : 16;
         p = s ? 8'hff : rnd();
         d0 = rnd();
         d1 = rnd();
         wq.delete();
         ersp_master_inst.start();
         wb(abyte(DIR_WRITE), 1'b0);
         chk("addressed", 8'h01, {7'h00, addressed_o});
         wb(p, 1'b0);
         wb(d0, 1'b0);
         wb(d1, 1'b0);
         ersp_master_inst.stop();
         chk("wadr0", p, wq[0][15:8]);
         chk("wdat0", d0, wq[0][7:0]);
         chk("wadr1", p + 8'h01, wq[1][15:8]);
         chk("wdat1", d1, wq[1][7:0]);
         chk("idle", 8'h01, {7'h00, bus_idle_o});
         p = rnd();
         ersp_master_inst.start();
         wb(abyte(DIR_WRITE), 1'b0);
         wb(p, 1'b0);
         ersp_master_inst.start();
         wb(abyte(DIR_READ), 1'b0);
         ersp_master_inst.bit9(9'h1fe, rx);
         chk("rd0", mem[p], rx[8:1]);
         ersp_master_inst.bit9(9'h1ff, rx);
         chk("rd1", mem[p + 8'h01], rx[8:1]);
         repeat (10) @(negedge clk_i);
         chk("release", 8'h01, {7'h00, sda});
         ersp_master_inst.stop();
         $display("write and read at speed %0d done", s);
      end
      ersp_master_inst.start();
      wb({SLAVE_ADDR ^ 7'h01, DIR_WRITE}, 1'b1);
      wb(abyte(DIR_WRITE), 1'b1);
      chk("addressed", 8'h00, {7'h00, addressed_o});
      ersp_master_inst.stop();
      $display("foreign address done");
      give_verdict();
   end
endmodule
